// ### dv/ccr_core_state_bench.sv
`timescale 1ns/100ps
module ccr_core_state_bench;
    logic        clk = 0, srst = 1, w8 = 0, w16 = 0, dwe = 0;
    logic [4:0]  ra = 0, rb = 0, r16 = 0, a8 = 0, a16 = 0, breg = 0;
    logic [7:0]  d8 = 0, dwd = 0, st, da, db, dsr, iod, v;
    logic [15:0] d16 = 0, dsa = 0, sp, rd16, pa, p;
    logic [5:0]  ctl = 0;
    logic [2:0]  bsel = 0;
    logic        hit, ien;
    int          error_cnt = 0, check_count = 0;
    ccr_pkg::ccr_alu_req_s alu;
    ccr_pkg::ccr_io_req_s  io;
    ccr_pkg::ccr_ptr_req_s pr;
    ccr_pkg::ccr_sp_op_e   spo;
    always #10 clk = ~clk;
    ccr_decoder_model m_u (.i_ref_clk(clk), .i_io_rdata(iod), .i_ptr_addr(pa), .o_alu(alu),
        .o_io(io), .o_ptr(pr), .o_sp_op(spo));
    ccr_core_state dut_u (.i_ref_clk(clk), .i_srst(srst), .i_alu(alu), .i_rd_a_addr(ra),
        .i_rd_b_addr(rb), .o_rd_a_data(da), .o_rd_b_data(db), .i_wr8_en(w8), .i_wr8_addr(a8),
        .i_wr8_data(d8), .i_wr16_en(w16), .i_wr16_addr(a16), .i_wr16_data(d16),
        .i_rd16_addr(r16), .o_rd16_data(rd16), .i_ds_we(dwe), .i_ds_addr(dsa),
        .i_ds_wdata(dwd), .o_ds_rdata(dsr), .o_ds_hit(hit), .i_ptr(pr), .o_ptr_addr(pa),
        .i_io(io), .o_io_rdata(iod), .i_sp_op(spo), .o_sp(sp), .i_irq_taken(ctl[5]),
        .i_return_from_interrupt(ctl[4]), .i_sei(ctl[3]), .i_cli(ctl[2]), .i_bst(ctl[1]), .i_bld(ctl[0]),
        .i_bit_reg(breg), .i_bit_sel(bsel), .o_status(st), .o_irq_enable(ien));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic s, input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        {w8, a8, d8} <= {~s, a, d[7:0]};
        {w16, a16, d16} <= {s, a, d};
        @(posedge clk);
        {w8, w16} <= 2'b00;
        #1;
    endtask : wr
    task automatic pulse(input logic [5:0] c, input logic [4:0] r, input logic [2:0] b);
        @(posedge clk);
        {ctl, breg, bsel} <= {c, r, b};
        @(posedge clk);
        ctl <= 6'h00;
        #1;
    endtask : pulse
    task automatic ds(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        {dwe, dsa, dwd} <= {1'b1, a, d};
        @(posedge clk);
        dwe <= 1'b0;
        #1;
    endtask : ds
    task automatic alu_chk(input ccr_pkg::ccr_alu_op_e op, input logic [4:0] rd,
                           input logic [4:0] rr, input logic ie, input logic [7:0] imm,
                           input logic [7:0] er, input logic [7:0] es);
        m_u.alu(op, rd, rr, ie, imm);
        @(posedge clk);
        rb <= rd;
        #1;
        chk("alu_result", {8'h00, er}, {8'h00, db});
        chk("status", {8'h00, es}, {8'h00, st});
    endtask : alu_chk
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        m_u.io_rd(6'h3D, v);
        chk("sp_low", 16'h0000, {8'h00, v});
        m_u.io_rd(6'h3E, v);
        chk("sp_high", 16'h0000, {8'h00, v});
        chk("status", 16'h0000, {8'h00, st});
        $display("test reset done");
        wr(0, 5'h01, 16'h000F);
        wr(0, 5'h02, 16'h0001);
        m_u.alu(ccr_pkg::CCR_OP_ADD, 5'h01, 5'h02, 1'b0, 8'h00);
        @(posedge clk);
        {ra, rb} <= {5'h01, 5'h02};
        #1;
        chk("sum", 16'h0010, {8'h00, da});
        chk("status", 16'h0020, {8'h00, st});
        m_u.alu(ccr_pkg::CCR_OP_ADD, 5'h01, 5'h00, 1'b1, 8'h70);
        chk("sum", 16'h0080, {8'h00, da});
        chk("status", 16'h000C, {8'h00, st});
        wr(0, 5'h05, 16'h00FF);
        m_u.alu(ccr_pkg::CCR_OP_ADD, 5'h05, 5'h02, 1'b0, 8'h00);
        chk("status", 16'h0023, {8'h00, st});
        alu_chk(ccr_pkg::CCR_OP_SUB, 5'h02, 5'h01, 1'b0, 8'h00, 8'h81, 8'h0D);
        alu_chk(ccr_pkg::CCR_OP_AND, 5'h02, 5'h00, 1'b1, 8'h80, 8'h80, 8'h15);
        alu_chk(ccr_pkg::CCR_OP_MOV, 5'h02, 5'h00, 1'b1, 8'h00, 8'h00, 8'h15);
        alu_chk(ccr_pkg::CCR_OP_OR, 5'h02, 5'h00, 1'b1, 8'h00, 8'h00, 8'h03);
        alu_chk(ccr_pkg::CCR_OP_SBC, 5'h02, 5'h00, 1'b1, 8'h00, 8'hFF, 8'h35);
        alu_chk(ccr_pkg::CCR_OP_XOR, 5'h02, 5'h00, 1'b1, 8'hFF, 8'h00, 8'h23);
        alu_chk(ccr_pkg::CCR_OP_ADC, 5'h01, 5'h01, 1'b1, 8'h7F, 8'h00, 8'h23);
        $display("test alu done");
        pulse(6'h08, 5'h00, 3'h0);
        chk("status", 16'h00A3, {8'h00, st});
        pulse(6'h20, 5'h00, 3'h0);
        chk("status", 16'h0023, {8'h00, st});
        chk("irq_en", 16'h0000, {15'h0, ien});
        pulse(6'h10, 5'h00, 3'h0);
        chk("irq_en", 16'h0001, {15'h0, ien});
        pulse(6'h04, 5'h00, 3'h0);
        chk("status", 16'h0023, {8'h00, st});
        wr(0, 5'h03, 16'h0004);
        pulse(6'h02, 5'h03, 3'h2);
        chk("status", 16'h0063, {8'h00, st});
        pulse(6'h01, 5'h04, 3'h7);
        @(posedge clk);
        rb <= 5'h04;
        #1;
        chk("bit_load", 16'h0080, {8'h00, db});
        $display("test flags done");
        @(posedge clk);
        dsa <= 16'h0004;
        #1;
        chk("ds_read", 16'h0180, {7'h0, hit, dsr});
        ds(16'h001F, 8'h5A);
        @(posedge clk);
        ra <= 5'h1F;
        #1;
        chk("ds_write", 16'h005A, {8'h00, da});
        ds(16'h0020, 8'hAA);
        chk("ds_miss", 16'h0000, {7'h0, hit, dsr});
        @(posedge clk);
        ra <= 5'h00;
        #1;
        chk("ds_refused", 16'h0000, {8'h00, da});
        $display("test data space done");
        m_u.io_wr(6'h3D, 8'h10);
        m_u.io_wr(6'h3E, 8'h01);
        chk("sp", 16'h0110, sp);
        m_u.sp(ccr_pkg::CCR_SP_PUSH1);
        chk("sp", 16'h010F, sp);
        m_u.sp(ccr_pkg::CCR_SP_PUSH2);
        chk("sp", 16'h010D, sp);
        m_u.sp(ccr_pkg::CCR_SP_POP2);
        chk("sp", 16'h010F, sp);
        m_u.sp(ccr_pkg::CCR_SP_POP1);
        chk("sp", 16'h0110, sp);
        $display("test stack done");
        wr(1, 5'h1A, 16'h0040);
        @(posedge clk);
        r16 <= 5'h1A;
        m_u.ptr(2'd0, ccr_pkg::CCR_PM_DISP, 6'h05, p);
        chk("ptr_disp", 16'h0045, p);
        m_u.ptr(2'd0, ccr_pkg::CCR_PM_POSTINC, 6'h00, p);
        chk("ptr_inc_addr", 16'h0040, p);
        chk("ptr_inc", 16'h0041, rd16);
        m_u.ptr(2'd0, ccr_pkg::CCR_PM_PREDEC, 6'h00, p);
        chk("ptr_dec", 16'h0040, p);
        wr(1, 5'h1E, 16'h1234);
        m_u.ptr(2'd2, ccr_pkg::CCR_PM_DISP, 6'h00, p);
        chk("ptr_pair", 16'h1234, p);
        $display("test pointer done");
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        chk("sp", 16'h0000, sp);
        chk("status", 16'h0000, {8'h00, st});
        chk("rd16", 16'h0000, rd16);
        $display("test mid reset done");
        report_and_stop();
    end
endmodule : ccr_core_state_bench

// ### dv/ccr_decoder_model.sv
`timescale 1ns/100ps
// Decoder side: requests launch after an edge and drop after the edge that takes them
module ccr_decoder_model (
    input  wire logic              i_ref_clk,
    input  wire logic [7:0]        i_io_rdata,
    input  wire logic [15:0]       i_ptr_addr,
    output ccr_pkg::ccr_alu_req_s  o_alu,
    output ccr_pkg::ccr_io_req_s   o_io,
    output ccr_pkg::ccr_ptr_req_s  o_ptr,
    output ccr_pkg::ccr_sp_op_e    o_sp_op
);
    initial
    begin
        o_alu   = '0;
        o_io    = '0;
        o_ptr   = '0;
        o_sp_op = ccr_pkg::CCR_SP_HOLD;
    end
    task automatic alu(input ccr_pkg::ccr_alu_op_e op, input logic [4:0] rd, input logic [4:0] rr,
                       input logic ie, input logic [7:0] imm);
        @(posedge i_ref_clk);
        o_alu <= '{1'b1, op, rd, rr, ie, imm};
        @(posedge i_ref_clk);
        o_alu <= '0;
        #1;
    endtask : alu
    task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_io <= '{1'b1, 1'b0, a, d};
        @(posedge i_ref_clk);
        o_io <= '0;
        #1;
    endtask : io_wr
    task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_io <= '{1'b0, 1'b1, a, 8'h00};
        #1;
        d = i_io_rdata;
        @(posedge i_ref_clk);
        o_io <= '0;
        #1;
    endtask : io_rd
    // Stack steps: one for data, two for return addresses
    task automatic sp(input ccr_pkg::ccr_sp_op_e op);
        @(posedge i_ref_clk);
        o_sp_op <= op;
        @(posedge i_ref_clk);
        o_sp_op <= ccr_pkg::CCR_SP_HOLD;
        #1;
    endtask : sp
    task automatic ptr(input logic [1:0] s, input ccr_pkg::ccr_ptr_mode_e m, input logic [5:0] dp,
                       output logic [15:0] a);
        @(posedge i_ref_clk);
        o_ptr <= '{1'b1, s, m, dp};
        #1;
        a = i_ptr_addr;
        @(posedge i_ref_clk);
        o_ptr <= '0;
        #1;
    endtask : ptr
endmodule : ccr_decoder_model

// ### verilog/ccr_consts.svh
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH
// Behaviour
// - ALU finishes an operation in one clock, register-register or register-immediate.
// - Flags update after every ALU operation except move, showing the latest result; AND, OR and XOR keep half carry and carry.
// - Status is never saved or restored automatically on interrupt entry or return.
// - Bit 7 is global interrupt enable; clear means all interrupts disabled.
// - Taking an interrupt clears bit 7; interrupt return sets it.
// - Set-enable instruction sets bit 7; clear-enable instruction clears it.
// - Bit 6 is transfer bit: bit-store copies register bit in, bit-load copies out.
// - Bit 5 is half carry, carry out of the low nibble.
// - Bit 4 sign equals negative xor overflow after every ALU flag update.
// - Bit 3 shows two's complement overflow.
// - Bit 2 set on negative result, cleared otherwise.
// - Bit 1 set on zero result, cleared otherwise.
// - Bit 0 shows carry of the operation.
// - Register file offers 8r/8w, 2x8r/8w, 2x8r/16w and 16r/16w port schemes.
// - The 32 working registers occupy data-space addresses 0 to 31.
// - Top six registers serve as three 16-bit pointers.
// - Pointer forms: displacement, post-increment and pre-decrement.
// - Stack grows down; data push decrements by one, pop increments by one.
// - Call or interrupt decrements stack by two; returns increment by two.
// - Stack pointer high and low bytes are I/O readable, writable, reset zero.
// - Core runs on the undivided clock.
`define CCR_IO_SPL      6'h3D
`define CCR_IO_SPH      6'h3E
`define CCR_IO_STATUS   6'h3F
`define CCR_SP_RESET    16'h0000
`define CCR_ST_RESET    8'h00
`define CCR_BIT_IE      7
`define CCR_BIT_T       6
`define CCR_BIT_H       5
`define CCR_BIT_S       4
`define CCR_BIT_V       3
`define CCR_BIT_N       2
`define CCR_BIT_Z       1
`define CCR_BIT_C       0
`define CCR_PTR_BASE    5'h1A
`define CCR_RF_TOP      16'h0020
`endif

// ### verilog/ccr_core_state.sv
`timescale 1ns/100ps
`include "ccr_consts.svh"
// Clocked on the undivided core clock; no divider anywhere in front.
module ccr_core_state (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_srst,
    input  wire ccr_pkg::ccr_alu_req_s i_alu,
    input  wire logic [4:0]           i_rd_a_addr,
    input  wire logic [4:0]           i_rd_b_addr,
    output logic [7:0]                o_rd_a_data,
    output logic [7:0]                o_rd_b_data,
    input  wire logic                 i_wr8_en,
    input  wire logic [4:0]           i_wr8_addr,
    input  wire logic [7:0]           i_wr8_data,
    input  wire logic                 i_wr16_en,
    input  wire logic [4:0]           i_wr16_addr,
    input  wire logic [15:0]          i_wr16_data,
    input  wire logic [4:0]           i_rd16_addr,
    output logic [15:0]               o_rd16_data,
    input  wire logic                 i_ds_we,
    input  wire logic [15:0]          i_ds_addr,
    input  wire logic [7:0]           i_ds_wdata,
    output logic [7:0]                o_ds_rdata,
    output logic                      o_ds_hit,
    input  wire ccr_pkg::ccr_ptr_req_s i_ptr,
    output logic [15:0]               o_ptr_addr,
    input  wire ccr_pkg::ccr_io_req_s i_io,
    output logic [7:0]                o_io_rdata,
    input  wire ccr_pkg::ccr_sp_op_e  i_sp_op,
    output logic [15:0]               o_sp,
    input  wire logic                 i_irq_taken,
    input  wire logic                 i_return_from_interrupt,
    input  wire logic                 i_sei,
    input  wire logic                 i_cli,
    input  wire logic                 i_bst,
    input  wire logic                 i_bld,
    input  wire logic [4:0]           i_bit_reg,
    input  wire logic [2:0]           i_bit_sel,
    output logic [7:0]                o_status,
    output logic                      o_irq_enable
);
    logic [7:0]  rf_q [32];
    logic [7:0]  st_q;
    logic [15:0] sp_q;
    logic [7:0]  op_a, op_b, res;
    logic [8:0]  sum9;
    logic        cin, h_f, v_f, c_f, n_f, z_f, upd, arith, sub;
    logic [4:0]  pr_lo;
    logic [15:0] ptr_cur, ptr_new;
    logic [4:0]  nib_sum;

    // Operands from two registers or a register and an immediate
    always_comb
    begin
        op_a  = rf_q[i_alu.rd];
        op_b  = i_alu.use_imm ? i_alu.imm : rf_q[i_alu.rr];
        sub   = (i_alu.op == ccr_pkg::CCR_OP_SUB) || (i_alu.op == ccr_pkg::CCR_OP_SBC);
        arith = sub || (i_alu.op == ccr_pkg::CCR_OP_ADD) || (i_alu.op == ccr_pkg::CCR_OP_ADC);
        cin   = ((i_alu.op == ccr_pkg::CCR_OP_ADC) || (i_alu.op == ccr_pkg::CCR_OP_SBC))
                && st_q[`CCR_BIT_C];
        sum9  = 9'h000;
        res   = 8'h00;
        h_f   = st_q[`CCR_BIT_H];
        v_f   = 1'b0;
        c_f   = st_q[`CCR_BIT_C];
        unique case (i_alu.op)
            ccr_pkg::CCR_OP_ADD, ccr_pkg::CCR_OP_ADC:
            begin
                sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
                res  = sum9[7:0];
                h_f  = (op_a[3] & op_b[3]) | (op_b[3] & ~res[3]) | (~res[3] & op_a[3]);
                v_f  = (op_a[7] & op_b[7] & ~res[7]) | (~op_a[7] & ~op_b[7] & res[7]);
                c_f  = sum9[8];
            end
            ccr_pkg::CCR_OP_SUB, ccr_pkg::CCR_OP_SBC:
            begin
                sum9 = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
                res  = sum9[7:0];
                h_f  = (~op_a[3] & op_b[3]) | (op_b[3] & res[3]) | (res[3] & ~op_a[3]);
                v_f  = (op_a[7] & ~op_b[7] & ~res[7]) | (~op_a[7] & op_b[7] & res[7]);
                c_f  = sum9[8];
            end
            ccr_pkg::CCR_OP_AND: res = op_a & op_b;
            ccr_pkg::CCR_OP_OR:  res = op_a | op_b;
            ccr_pkg::CCR_OP_XOR: res = op_a ^ op_b;
            ccr_pkg::CCR_OP_MOV: res = op_b;
            default:             res = 8'h00;
        endcase
        n_f = res[7];
        z_f = (res == 8'h00);
        upd = i_alu.valid && (i_alu.op != ccr_pkg::CCR_OP_NONE)
              && (i_alu.op != ccr_pkg::CCR_OP_MOV);
    end

    // Pointer pair select, even register low byte
    always_comb
    begin
        pr_lo   = 5'(`CCR_PTR_BASE + {i_ptr.sel, 1'b0});
        ptr_cur = {rf_q[pr_lo + 5'd1], rf_q[pr_lo]};
        ptr_new = ptr_cur;
        o_ptr_addr = ptr_cur;
        unique case (i_ptr.mode)
            ccr_pkg::CCR_PM_DISP:    o_ptr_addr = ptr_cur + {10'h000, i_ptr.disp};
            ccr_pkg::CCR_PM_POSTINC: ptr_new = ptr_cur + 16'h0001;
            ccr_pkg::CCR_PM_PREDEC:
            begin
                ptr_new    = ptr_cur - 16'h0001;
                o_ptr_addr = ptr_new;
            end
            default:                 o_ptr_addr = ptr_cur;
        endcase
    end

    // Several write sources per cycle; on a shared register the last listed wins
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            for (int i = 0; i < 32; i++) rf_q[i] <= 8'h00;
        end
        else
        begin
            if (i_alu.valid && i_alu.op != ccr_pkg::CCR_OP_NONE) rf_q[i_alu.rd] <= res;
            if (i_wr8_en) rf_q[i_wr8_addr] <= i_wr8_data;
            if (i_wr16_en)
            begin
                rf_q[i_wr16_addr]        <= i_wr16_data[7:0];
                rf_q[i_wr16_addr + 5'd1] <= i_wr16_data[15:8];
            end
            if (i_ds_we && i_ds_addr < `CCR_RF_TOP) rf_q[i_ds_addr[4:0]] <= i_ds_wdata;
            if (i_ptr.valid && i_ptr.mode != ccr_pkg::CCR_PM_DISP)
            begin
                rf_q[pr_lo]        <= ptr_new[7:0];
                rf_q[pr_lo + 5'd1] <= ptr_new[15:8];
            end
            if (i_bld) rf_q[i_bit_reg][i_bit_sel] <= st_q[`CCR_BIT_T];
        end
    end

    assign o_rd_a_data = rf_q[i_rd_a_addr];
    assign o_rd_b_data = rf_q[i_rd_b_addr];
    assign o_rd16_data = {rf_q[i_rd16_addr + 5'd1], rf_q[i_rd16_addr]};
    assign o_ds_hit    = i_ds_addr < `CCR_RF_TOP;
    assign o_ds_rdata  = o_ds_hit ? rf_q[i_ds_addr[4:0]] : 8'h00;

    // Status: irq entry/return only touch bit 7, never a save/restore
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
            st_q <= `CCR_ST_RESET;
        else
        begin
            if (i_io.we && i_io.addr == `CCR_IO_STATUS) st_q <= i_io.wdata;
            if (upd)
            begin
                st_q[`CCR_BIT_N] <= n_f;
                st_q[`CCR_BIT_Z] <= z_f;
                st_q[`CCR_BIT_V] <= v_f;
                st_q[`CCR_BIT_S] <= n_f ^ v_f;
                if (arith)
                begin
                    st_q[`CCR_BIT_H] <= h_f;
                    st_q[`CCR_BIT_C] <= c_f;
                end
            end
            if (i_bst) st_q[`CCR_BIT_T] <= rf_q[i_bit_reg][i_bit_sel];
            if (i_sei) st_q[`CCR_BIT_IE] <= 1'b1;
            if (i_cli) st_q[`CCR_BIT_IE] <= 1'b0;
            if (i_return_from_interrupt) st_q[`CCR_BIT_IE] <= 1'b1;
            if (i_irq_taken) st_q[`CCR_BIT_IE] <= 1'b0;
        end
    end

    // Stack pointer grows down; I/O byte writes take priority over push and pop steps
    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
            sp_q <= `CCR_SP_RESET;
        else if (i_io.we && i_io.addr == `CCR_IO_SPL)
            sp_q[7:0] <= i_io.wdata;
        else if (i_io.we && i_io.addr == `CCR_IO_SPH)
            sp_q[15:8] <= i_io.wdata;
        else
            unique case (i_sp_op)
                ccr_pkg::CCR_SP_PUSH1: sp_q <= sp_q - 16'h0001;
                ccr_pkg::CCR_SP_POP1:  sp_q <= sp_q + 16'h0001;
                ccr_pkg::CCR_SP_PUSH2: sp_q <= sp_q - 16'h0002;
                ccr_pkg::CCR_SP_POP2:  sp_q <= sp_q + 16'h0002;
                default:               sp_q <= sp_q;
            endcase
    end

    always_comb
    begin
        // Zero unless a read is asked for, so idle cycles show no stale byte
        o_io_rdata = 8'h00;
        if (i_io.re)
        begin
            unique case (i_io.addr)
                `CCR_IO_SPL:    o_io_rdata = sp_q[7:0];
                `CCR_IO_SPH:    o_io_rdata = sp_q[15:8];
                `CCR_IO_STATUS: o_io_rdata = st_q;
                default:        o_io_rdata = 8'h00;
            endcase
        end
    end

    assign o_sp         = sp_q;
    assign o_status     = st_q;
    assign o_irq_enable = st_q[`CCR_BIT_IE];
    // Independent low-nibble sum, so the half-carry check does not reuse h_f
    assign nib_sum      = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};

    property p_sign;
        @(posedge i_ref_clk) disable iff (i_srst)
        o_status[`CCR_BIT_S] == (o_status[`CCR_BIT_N] ^ o_status[`CCR_BIT_V]) || !$past(upd);
    endproperty
    a_sign: assert property (p_sign) else $error("sign not n xor v");

    property p_irq_clr;
        @(posedge i_ref_clk) disable iff (i_srst) i_irq_taken |=> !o_irq_enable;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("ie not cleared");

    property p_return_from_interrupt;
        @(posedge i_ref_clk) disable iff (i_srst) (i_return_from_interrupt && !i_irq_taken) |=> o_irq_enable;
    endproperty
    a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("ie not set on return");

    property p_sei;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_sei && !i_cli && !i_irq_taken) |=> o_irq_enable;
    endproperty
    a_sei: assert property (p_sei) else $error("sei failed");

    property p_zero;
        @(posedge i_ref_clk) disable iff (i_srst)
        (upd && !i_io.we) |=> o_status[`CCR_BIT_Z] == $past(z_f);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    property p_push2;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_sp_op == ccr_pkg::CCR_SP_PUSH2 && !i_io.we) |=> o_sp == $past(o_sp) - 16'h0002;
    endproperty
    a_push2: assert property (p_push2) else $error("push2 step wrong");

    property p_pop1;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_sp_op == ccr_pkg::CCR_SP_POP1 && !i_io.we) |=> o_sp == $past(o_sp) + 16'h0001;
    endproperty
    a_pop1: assert property (p_pop1) else $error("pop1 step wrong");

    property p_sp_reset;
        @(posedge i_ref_clk) i_srst |=> o_sp == 16'h0000;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("sp reset wrong");

    property p_cli;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_cli && !i_return_from_interrupt && !i_irq_taken) |=> !o_irq_enable;
    endproperty
    a_cli: assert property (p_cli) else $error("cli failed");

    sequence s_add_req;
        i_alu.valid
        && (i_alu.op == ccr_pkg::CCR_OP_ADD || i_alu.op == ccr_pkg::CCR_OP_ADC);
    endsequence

    property p_half;
        @(posedge i_ref_clk) disable iff (i_srst)
        s_add_req |=> o_status[`CCR_BIT_H] == $past(nib_sum[4]);
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong");

    property p_add_v;
        @(posedge i_ref_clk) disable iff (i_srst)
        s_add_req |=> o_status[`CCR_BIT_V] == $past(op_a[7] == op_b[7] && res[7] != op_a[7]);
    endproperty
    a_add_v: assert property (p_add_v) else $error("add overflow wrong");

    sequence s_logic_req;
        i_alu.valid && !i_io.we && (i_alu.op == ccr_pkg::CCR_OP_AND
        || i_alu.op == ccr_pkg::CCR_OP_OR || i_alu.op == ccr_pkg::CCR_OP_XOR);
    endsequence

    property p_logic_flags;
        @(posedge i_ref_clk) disable iff (i_srst)
        s_logic_req |=> !o_status[`CCR_BIT_V] && $stable(o_status[`CCR_BIT_C]);
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong");

    property p_neg;
        @(posedge i_ref_clk) disable iff (i_srst)
        upd |=> o_status[`CCR_BIT_N] == $past(res[7]);
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag wrong");

    property p_bst;
        @(posedge i_ref_clk) disable iff (i_srst)
        i_bst |=> o_status[`CCR_BIT_T] == $past(rf_q[i_bit_reg][i_bit_sel]);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong");

    property p_push1;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_sp_op == ccr_pkg::CCR_SP_PUSH1 && !i_io.we) |=> o_sp == $past(o_sp) - 16'h0001;
    endproperty
    a_push1: assert property (p_push1) else $error("push1 step wrong");

    property p_pop2;
        @(posedge i_ref_clk) disable iff (i_srst)
        (i_sp_op == ccr_pkg::CCR_SP_POP2 && !i_io.we) |=> o_sp == $past(o_sp) + 16'h0002;
    endproperty
    a_pop2: assert property (p_pop2) else $error("pop2 step wrong");
endmodule : ccr_core_state

// ### verilog/ccr_pkg.sv
package ccr_pkg;
    typedef enum logic [3:0] {
        CCR_OP_NONE, CCR_OP_ADD, CCR_OP_ADC, CCR_OP_SUB, CCR_OP_SBC,
        CCR_OP_AND, CCR_OP_OR, CCR_OP_XOR, CCR_OP_MOV
    } ccr_alu_op_e;
    typedef enum logic [2:0] {
        CCR_SP_HOLD, CCR_SP_PUSH1, CCR_SP_POP1, CCR_SP_PUSH2, CCR_SP_POP2
    } ccr_sp_op_e;
    typedef enum logic [1:0] {
        CCR_PM_DISP, CCR_PM_POSTINC, CCR_PM_PREDEC
    } ccr_ptr_mode_e;
    typedef struct packed {
        logic        valid;
        ccr_alu_op_e op;
        logic [4:0]  rd;
        logic [4:0]  rr;
        logic        use_imm;
        logic [7:0]  imm;
    } ccr_alu_req_s;
    typedef struct packed {
        logic       valid;
        logic [1:0] sel;
        ccr_ptr_mode_e mode;
        logic [5:0] disp;
    } ccr_ptr_req_s;
    typedef struct packed {
        logic        we;
        logic        re;
        logic [5:0]  addr;
        logic [7:0]  wdata;
    } ccr_io_req_s;
endpackage : ccr_pkg
